// ==== rtl/frst_pkg.sv ====
// constants, op codes and state types for the flash reset/suspend timing pair
// assumes a single 125 MHz core clock shared by both ends
package frst_pkg;
   localparam real CLK_MHZ = 125.0;

   localparam real RST_PULSE_NS      = 50.0;
   localparam real SHORT_REC_NS      = 40.0;
   localparam real ARRAY_REC_US      = 30.0;
   localparam real STATUS_WRITE_MS   = 8.0;
   localparam real NVCFG_WRITE_S     = 1.0;
   localparam real SSE_TIME_S        = 0.4;
   localparam real PDOWN_EXIT_US     = 30.0;
   localparam real PROT_PROG_MS      = 0.5;
   localparam real PASS_PROG_MS      = 8.0;
   localparam real PROG_SUSP_LAT_US  = 25.0;
   localparam real ERASE_SUSP_LAT_US = 30.0;
   localparam real ERASE_RUN_US      = 150.0;
   localparam real PROG_RUN_US       = 5.0;
   localparam real SSE_RUN_US        = 50.0;

   // least times round up, suspend latencies (longest) round down
   localparam int unsigned RST_PULSE_CYC =
      int'($ceil(RST_PULSE_NS * CLK_MHZ / 1000.0));
   localparam int unsigned SHORT_REC_CYC =
      int'($ceil(SHORT_REC_NS * CLK_MHZ / 1000.0));
   localparam int unsigned ARRAY_REC_CYC =
      int'($ceil(ARRAY_REC_US * CLK_MHZ));
   localparam int unsigned STATUS_WRITE_CYC =
      int'($ceil(STATUS_WRITE_MS * CLK_MHZ * 1000.0));
   localparam int unsigned NVCFG_WRITE_CYC =
      int'($ceil(NVCFG_WRITE_S * CLK_MHZ * 1000000.0));
   localparam int unsigned SSE_TIME_CYC =
      int'($ceil(SSE_TIME_S * CLK_MHZ * 1000000.0));
   localparam int unsigned PDOWN_EXIT_CYC =
      int'($ceil(PDOWN_EXIT_US * CLK_MHZ));
   localparam int unsigned PROT_PROG_CYC =
      int'($ceil(PROT_PROG_MS * CLK_MHZ * 1000.0));
   localparam int unsigned PASS_PROG_CYC =
      int'($ceil(PASS_PROG_MS * CLK_MHZ * 1000.0));
   localparam int unsigned PROG_SUSP_LAT_CYC =
      int'($floor(PROG_SUSP_LAT_US * CLK_MHZ));
   localparam int unsigned ERASE_SUSP_LAT_CYC =
      int'($floor(ERASE_SUSP_LAT_US * CLK_MHZ));
   localparam int unsigned ERASE_RUN_CYC =
      int'($ceil(ERASE_RUN_US * CLK_MHZ));
   localparam int unsigned PROG_RUN_CYC =
      int'($ceil(PROG_RUN_US * CLK_MHZ));
   localparam int unsigned SSE_RUN_CYC =
      int'($ceil(SSE_RUN_US * CLK_MHZ));

   typedef enum logic [4:0] {
      OP_NONE         = 5'h00, OP_READ         = 5'h01,
      OP_VOL_WRITE    = 5'h02, OP_PROGRAM      = 5'h03,
      OP_SECTOR_ERASE = 5'h04, OP_SUBSECT_ERASE = 5'h05,
      OP_BULK_ERASE   = 5'h06, OP_STATUS_WRITE = 5'h07,
      OP_NVCFG_WRITE  = 5'h08, OP_OTP_PROGRAM  = 5'h09,
      OP_LOCK_PROGRAM = 5'h0A, OP_LOCK_ERASE   = 5'h0B,
      OP_PROT_PROGRAM = 5'h0C, OP_PASS_PROGRAM = 5'h0D,
      OP_SUSPEND      = 5'h0E, OP_RESUME       = 5'h0F,
      OP_SOFT_RESET   = 5'h10, OP_POWER_DOWN   = 5'h11,
      OP_POWER_UP     = 5'h12
   } frst_op_t;

   typedef enum logic [2:0] {
      REC_SHORT = 3'h0, REC_ARRAY = 3'h1, REC_SRW  = 3'h2, REC_NVW = 3'h3,
      REC_SSE   = 3'h4, REC_ASP   = 3'h5, REC_PASS = 3'h6, REC_DPD = 3'h7
   } frst_rec_t;

   typedef enum logic [6:0] {
      D_STANDBY = 7'h01, D_BUSY    = 7'h02, D_SUSPENDING = 7'h04,
      D_SUSPEND = 7'h08, D_PDOWN   = 7'h10, D_WAKING     = 7'h20,
      D_RECOVER = 7'h40
   } frst_dmode_t;

   typedef enum logic [3:0] {
      H_IDLE = 4'h1, H_HOLD = 4'h2, H_PULSE = 4'h4, H_WAIT = 4'h8
   } frst_hmode_t;

   // ops that occupy the array engine until it reports done
   function automatic logic frst_starts(frst_op_t op);
      return op inside {OP_PROGRAM, OP_SECTOR_ERASE, OP_SUBSECT_ERASE,
                        OP_BULK_ERASE, OP_STATUS_WRITE, OP_NVCFG_WRITE,
                        OP_OTP_PROGRAM, OP_LOCK_PROGRAM, OP_LOCK_ERASE,
                        OP_PROT_PROGRAM, OP_PASS_PROGRAM};
   endfunction

   // recovery class after any reset, from what was running
   function automatic frst_rec_t frst_rec_sel(logic pd, frst_op_t op);
      if (pd)
         return REC_DPD;
      case (op)
         OP_NONE, OP_READ, OP_VOL_WRITE: return REC_SHORT;
         OP_STATUS_WRITE:                return REC_SRW;
         OP_NVCFG_WRITE:                 return REC_NVW;
         OP_SUBSECT_ERASE:               return REC_SSE;
         OP_PROT_PROGRAM:                return REC_ASP;
         OP_PASS_PROGRAM:                return REC_PASS;
         default:                        return REC_ARRAY;
      endcase
   endfunction
endpackage

// ==== rtl/frst_link_if.sv ====
// link between host controller end and flash device end
// one clock domain; both ends sample on core_clk rising edges
interface frst_link_if;
   import frst_pkg::*;
   logic     rst_pin_b;  // hardware reset pin, active low
   logic     cs_b;       // chip select, low one cycle per command
   frst_op_t cmd_op;     // command carried while cs_b is low
   logic     dev_ready;  // device accepts a selection
   logic     dev_susp;   // an operation is held suspended

   modport host (output rst_pin_b, output cs_b, output cmd_op,
                 input dev_ready, input dev_susp);
   modport dev  (input rst_pin_b, input cs_b, input cmd_op,
                 output dev_ready, output dev_susp);
endinterface

// ==== rtl/frst_dev.sv ====
// flash device end: reset recovery, suspend latency, command acceptance
// assumes an array engine on the user side that pulses eng_done
// Summary of operation
// - host holds reset pin low at least 50 ns
// - idle: ready 40 ns after release
// - decode, read, volatile write: 40 ns recovery
// - array, OTP, lock operations: 30 us recovery
// - other nonvolatile ops: recovery equals their cycle time
// - soft reset: 40 ns idle, 30 us array ops
// - soft reset in slow ops: their cycle time
// - host runs sector erase 150 us before suspend
// - host runs program 5 us before suspend
// - host runs subsector erase 50 us before suspend
// - program/subsector suspend done in time, reads only
// - erase suspend 30 us, most commands then accepted
// - power-down exit takes 30 us from deselect
// - status write recovery bounded by 8 ms
// - subsector erase recovery bounded by 0.4 s
module frst_dev #(
   parameter int unsigned STATUS_WRITE_CYC = frst_pkg::STATUS_WRITE_CYC,
   parameter int unsigned NVCFG_WRITE_CYC  = frst_pkg::NVCFG_WRITE_CYC,
   parameter int unsigned SSE_TIME_CYC     = frst_pkg::SSE_TIME_CYC,
   parameter int unsigned PROT_PROG_CYC    = frst_pkg::PROT_PROG_CYC,
   parameter int unsigned PASS_PROG_CYC    = frst_pkg::PASS_PROG_CYC
) (
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   frst_link_if.dev           lk,
   input  wire logic          eng_done,
   output frst_pkg::frst_op_t eng_op,
   output logic               eng_run,
   output logic               eng_susp
);
   import frst_pkg::*;

   typedef struct packed {
      frst_dmode_t mode;
      frst_op_t    op;
      frst_op_t    sop;
      logic        nest;
      logic [31:0] cnt;
      logic        ready;
      logic        susp;
      logic        run;
      logic        rst_seen;
   } frst_dev_st_t;

   frst_dev_st_t s_r;
   frst_dev_st_t s_nxt;
   logic         take;
   frst_op_t     cmd;

   assign take      = ~lk.cs_b & s_r.ready;
   assign cmd       = lk.cmd_op;
   assign eng_op    = s_r.op;
   assign eng_run   = s_r.run;
   assign eng_susp  = s_r.susp;
   assign lk.dev_ready = s_r.ready;
   assign lk.dev_susp  = s_r.susp;

   function automatic logic [31:0] rec_cyc(frst_rec_t c);
      unique case (c)
         REC_SHORT: return 32'(SHORT_REC_CYC);
         REC_ARRAY: return 32'(ARRAY_REC_CYC);
         REC_SRW:   return 32'(STATUS_WRITE_CYC);
         REC_NVW:   return 32'(NVCFG_WRITE_CYC);
         REC_SSE:   return 32'(SSE_TIME_CYC);
         REC_ASP:   return 32'(PROT_PROG_CYC);
         REC_PASS:  return 32'(PASS_PROG_CYC);
         REC_DPD:   return 32'(PDOWN_EXIT_CYC);
      endcase
   endfunction

   // any reset aborts the engine and parks in recovery
   function automatic frst_dev_st_t to_recover(frst_dev_st_t x);
      logic pd;
      pd = (x.mode == D_PDOWN) || (x.mode == D_WAKING);
      x.cnt  = rec_cyc(frst_rec_sel(pd, x.op));
      x.mode = D_RECOVER;
      x.op   = OP_NONE;
      x.sop  = OP_NONE;
      x.nest = 1'b0;
      x.susp = 1'b0;
      x.run  = 1'b0;
      return x;
   endfunction

   // commands legal while an operation sits suspended
   function automatic logic susp_ok(frst_op_t held, frst_op_t c);
      if (held == OP_SECTOR_ERASE)
         return !(c inside {OP_SECTOR_ERASE, OP_SUBSECT_ERASE,
                            OP_BULK_ERASE, OP_STATUS_WRITE,
                            OP_NVCFG_WRITE, OP_OTP_PROGRAM,
                            OP_SUSPEND, OP_POWER_DOWN,
                            OP_POWER_UP});
      return c == OP_READ;
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (!lk.rst_pin_b) begin
         // any low level counts; short pulses are the host's risk
         s_nxt.rst_seen = 1'b1;
         s_nxt.run      = 1'b0;
         // held op is lost at once, not only when the pin returns
         s_nxt.susp     = 1'b0;
      end else if (s_r.rst_seen) begin
         s_nxt          = to_recover(s_r);
         s_nxt.rst_seen = 1'b0;
      end else begin
         unique case (s_r.mode)
            D_STANDBY: begin
               if (take) begin
                  if (cmd == OP_SOFT_RESET) begin
                     s_nxt = to_recover(s_r);
                  end else if (cmd == OP_POWER_DOWN) begin
                     s_nxt.mode = D_PDOWN;
                  end else if (frst_starts(cmd)) begin
                     s_nxt.mode = D_BUSY;
                     s_nxt.op   = cmd;
                     s_nxt.run  = 1'b1;
                  end
               end
            end
            D_BUSY: begin
               if (eng_done) begin
                  s_nxt.run  = 1'b0;
                  s_nxt.nest = 1'b0;
                  s_nxt.mode = s_r.nest ? D_SUSPEND : D_STANDBY;
                  s_nxt.op   = s_r.nest ? s_r.sop : OP_NONE;
                  s_nxt.sop  = OP_NONE;
               end else if (take && cmd == OP_SOFT_RESET) begin
                  s_nxt = to_recover(s_r);
               end else if (take && cmd == OP_SUSPEND && !s_r.nest &&
                            s_r.op inside {OP_PROGRAM, OP_SECTOR_ERASE,
                                           OP_SUBSECT_ERASE}) begin
                  // engine stops at once; the wait models latency
                  s_nxt.mode = D_SUSPENDING;
                  s_nxt.run  = 1'b0;
                  s_nxt.cnt  = (s_r.op == OP_PROGRAM) ?
                               32'(PROG_SUSP_LAT_CYC) :
                               32'(ERASE_SUSP_LAT_CYC);
               end
            end
            D_SUSPENDING: begin
               if (s_r.cnt <= 32'h1) begin
                  s_nxt.mode = D_SUSPEND;
                  s_nxt.susp = 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt - 32'h1;
               end
            end
            D_SUSPEND: begin
               if (take) begin
                  if (cmd == OP_SOFT_RESET) begin
                     s_nxt = to_recover(s_r);
                  end else if (cmd == OP_RESUME) begin
                     s_nxt.mode = D_BUSY;
                     s_nxt.run  = 1'b1;
                     s_nxt.susp = 1'b0;
                  end else if (susp_ok(s_r.op, cmd) &&
                               frst_starts(cmd)) begin
                     // nested op runs while the erase stays held
                     s_nxt.mode = D_BUSY;
                     s_nxt.sop  = s_r.op;
                     s_nxt.op   = cmd;
                     s_nxt.nest = 1'b1;
                     s_nxt.run  = 1'b1;
                  end
               end
            end
            D_PDOWN: begin
               if (take && cmd == OP_POWER_UP) begin
                  s_nxt.mode = D_WAKING;
                  s_nxt.cnt  = 32'(PDOWN_EXIT_CYC);
               end else if (take && cmd == OP_SOFT_RESET) begin
                  s_nxt = to_recover(s_r);
               end
            end
            D_WAKING, D_RECOVER: begin
               if (s_r.cnt <= 32'h1) begin
                  s_nxt.mode = D_STANDBY;
               end else begin
                  s_nxt.cnt = s_r.cnt - 32'h1;
               end
            end
         endcase
      end
      s_nxt.ready = ~s_nxt.rst_seen &
                    (s_nxt.mode inside {D_STANDBY, D_BUSY, D_SUSPEND,
                                        D_PDOWN});
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{mode: D_STANDBY, op: OP_NONE, sop: OP_NONE,
                  nest: 1'b0, cnt: 32'h0, ready: 1'b1, susp: 1'b0,
                  run: 1'b0, rst_seen: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // frst_dev

// ==== rtl/frst_host.sv ====
// host controller end: reset pulse, recovery waits, suspend hold-off
// assumes user learns completions elsewhere and reports them on op_clear
module frst_host #(
   parameter int unsigned STATUS_WRITE_CYC = frst_pkg::STATUS_WRITE_CYC,
   parameter int unsigned NVCFG_WRITE_CYC  = frst_pkg::NVCFG_WRITE_CYC,
   parameter int unsigned SSE_TIME_CYC     = frst_pkg::SSE_TIME_CYC,
   parameter int unsigned PROT_PROG_CYC    = frst_pkg::PROT_PROG_CYC,
   parameter int unsigned PASS_PROG_CYC    = frst_pkg::PASS_PROG_CYC,
   parameter int unsigned ERASE_RUN_CYC    = frst_pkg::ERASE_RUN_CYC,
   parameter int unsigned SSE_RUN_CYC      = frst_pkg::SSE_RUN_CYC
) (
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   frst_link_if.host          lk,
   input  wire logic          req_valid,
   input  frst_pkg::frst_op_t req_op,
   output logic               req_ready,
   input  wire logic          hard_rst,
   input  wire logic          op_clear,
   output frst_pkg::frst_op_t pend_op,
   output logic               pend_susp
);
   import frst_pkg::*;

   typedef struct packed {
      frst_hmode_t mode;
      logic [31:0] cnt;
      logic [31:0] run;
      frst_op_t    pop;
      frst_op_t    sop;
      logic        psusp;
      logic        pdown;
      logic        cs_b;
      frst_op_t    cmd;
      logic        rst_pin_b;
      logic        rdy;
   } frst_host_st_t;

   frst_host_st_t s_r;
   frst_host_st_t s_nxt;

   assign lk.rst_pin_b = s_r.rst_pin_b;
   assign lk.cs_b      = s_r.cs_b;
   assign lk.cmd_op    = s_r.cmd;
   assign req_ready    = s_r.rdy;
   assign pend_op      = s_r.pop;
   assign pend_susp    = s_r.psusp;

   function automatic logic [31:0] rec_cyc(frst_rec_t c);
      unique case (c)
         REC_SHORT: return 32'(SHORT_REC_CYC);
         REC_ARRAY: return 32'(ARRAY_REC_CYC);
         REC_SRW:   return 32'(STATUS_WRITE_CYC);
         REC_NVW:   return 32'(NVCFG_WRITE_CYC);
         REC_SSE:   return 32'(SSE_TIME_CYC);
         REC_ASP:   return 32'(PROT_PROG_CYC);
         REC_PASS:  return 32'(PASS_PROG_CYC);
         REC_DPD:   return 32'(PDOWN_EXIT_CYC);
      endcase
   endfunction

   function automatic logic [31:0] susp_min(frst_op_t op);
      case (op)
         OP_SECTOR_ERASE:  return 32'(ERASE_RUN_CYC);
         OP_PROGRAM:       return 32'(PROG_RUN_CYC);
         OP_SUBSECT_ERASE: return 32'(SSE_RUN_CYC);
         default:          return 32'h0;
      endcase
   endfunction

   // the wait is picked from our own record, not from the device
   function automatic frst_host_st_t to_wait(frst_host_st_t x);
      x.cnt   = rec_cyc(frst_rec_sel(x.pdown, x.pop));
      x.mode  = H_WAIT;
      x.pop   = OP_NONE;
      x.sop   = OP_NONE;
      x.psusp = 1'b0;
      x.pdown = 1'b0;
      return x;
   endfunction

   function automatic frst_host_st_t issue(frst_host_st_t x, frst_op_t op);
      x.cs_b = 1'b0;
      x.cmd  = op;
      x.mode = H_IDLE;
      if (frst_starts(op)) begin
         x.sop = x.psusp ? x.pop : OP_NONE;
         x.pop = op;
         x.run = 32'h0;
      end else if (op == OP_SUSPEND) begin
         x.psusp = 1'b1;
      end else if (op == OP_RESUME) begin
         x.psusp = 1'b0;
         x.run   = 32'h0;
      end else if (op == OP_POWER_DOWN) begin
         x.pdown = 1'b1;
      end else if (op == OP_POWER_UP) begin
         x       = to_wait(x);
      end else if (op == OP_SOFT_RESET) begin
         x       = to_wait(x);
      end
      return x;
   endfunction

   always_comb begin
      s_nxt      = s_r;
      s_nxt.cs_b = 1'b1;
      s_nxt.cmd  = OP_NONE;
      if (s_r.run != 32'hFFFFFFFF)
         s_nxt.run = s_r.run + 32'h1;
      if (op_clear) begin
         s_nxt.pop = s_r.sop;
         s_nxt.sop = OP_NONE;
      end
      unique case (s_r.mode)
         H_IDLE, H_HOLD: begin
            if (hard_rst) begin
               s_nxt.mode      = H_PULSE;
               s_nxt.rst_pin_b = 1'b0;
               s_nxt.cnt       = 32'(RST_PULSE_CYC);
            end else if (s_r.mode == H_HOLD) begin
               if (s_r.run >= susp_min(s_r.pop))
                  s_nxt = issue(s_nxt, OP_SUSPEND);
            end else if (req_valid && s_r.rdy) begin
               if (req_op == OP_SUSPEND &&
                   s_r.run < susp_min(s_r.pop))
                  s_nxt.mode = H_HOLD;
               else
                  s_nxt = issue(s_nxt, req_op);
            end
         end
         H_PULSE: begin
            if (s_r.cnt <= 32'h1) begin
               s_nxt           = to_wait(s_nxt);
               s_nxt.rst_pin_b = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 32'h1;
            end
         end
         H_WAIT: begin
            if (s_r.cnt <= 32'h1)
               s_nxt.mode = H_IDLE;
            else
               s_nxt.cnt = s_r.cnt - 32'h1;
         end
      endcase
      // one deselected cycle always separates two commands
      s_nxt.rdy = (s_nxt.mode == H_IDLE) & s_nxt.cs_b & ~hard_rst;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{mode: H_IDLE, cnt: 32'h0, run: 32'h0, pop: OP_NONE,
                  sop: OP_NONE, psusp: 1'b0, pdown: 1'b0, cs_b: 1'b1,
                  cmd: OP_NONE, rst_pin_b: 1'b1, rdy: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // frst_host

// ==== verification/frst_assertions.sv ====
// checker for the link between the host end and the device end
// assumes it watches the one link interface of the bench, core_clk domain
module frst_assertions #(
   parameter int unsigned ERASE_RUN_CYC = frst_pkg::ERASE_RUN_CYC,
   parameter int unsigned SSE_RUN_CYC   = frst_pkg::SSE_RUN_CYC
) (
   input wire logic          core_clk,
   input wire logic          rst_b,
   input wire logic          rst_pin_b,
   input wire logic          cs_b,
   input frst_pkg::frst_op_t cmd_op,
   input wire logic          dev_ready,
   input wire logic          dev_susp
);
   timeunit 1ns;
   timeprecision 1ps;
   import frst_pkg::*;
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] run;
      logic [15:0] min;
   } frst_chk_t;
   frst_chk_t st_r;
   frst_chk_t st_nxt;
   logic      lift;
   // a suspend may only be lifted by resume, soft reset or the reset pin
   assign lift = !rst_pin_b ||
                 (!cs_b && (cmd_op == OP_RESUME || cmd_op == OP_SOFT_RESET));
   always_comb begin
      st_nxt     = st_r;
      st_nxt.lo  = dev_ready ? 16'h0000 : st_r.lo + 16'h0001;
      st_nxt.run = (&st_r.run) ? st_r.run : st_r.run + 16'h0001;
      if (!cs_b && cmd_op inside {OP_PROGRAM, OP_SECTOR_ERASE,
                                  OP_SUBSECT_ERASE, OP_RESUME}) begin
         st_nxt.run = 16'h0000;
      end
      if (!cs_b) begin
         case (cmd_op)
            OP_PROGRAM:       st_nxt.min = 16'(PROG_RUN_CYC);
            OP_SECTOR_ERASE:  st_nxt.min = 16'(ERASE_RUN_CYC);
            OP_SUBSECT_ERASE: st_nxt.min = 16'(SSE_RUN_CYC);
            default:          st_nxt.min = st_r.min;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   property p_pulse;
      $fell(rst_pin_b) |-> (!rst_pin_b) [*7];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("reset pin pulse shorter than 7 cycles");
   property p_select;
      !cs_b |-> dev_ready && rst_pin_b;
   endproperty
   a_select: assert property (p_select)
      else $error("device selected while not ready");
   property p_drop;
      $fell(rst_pin_b) |-> ##[1:2] !dev_ready;
   endproperty
   a_drop: assert property (p_drop)
      else $error("ready kept through reset pin");
   property p_short_min;
      $rose(rst_pin_b) |-> (!dev_ready) [*5];
   endproperty
   a_short_min: assert property (p_short_min)
      else $error("recovery shorter than 5 cycles");
   property p_long_max;
      !dev_ready |-> st_r.lo < 16'h0EB5;
   endproperty
   a_long_max: assert property (p_long_max)
      else $error("ready low too long");
   property p_susp_rise;
      $rose(dev_susp) |-> dev_ready && !$past(dev_ready);
   endproperty
   a_susp_rise: assert property (p_susp_rise)
      else $error("suspend flag without latency");
   property p_latency;
      $rose(dev_susp) |-> $past(st_r.lo) inside {[3120:3755]};
   endproperty
   a_latency: assert property (p_latency)
      else $error("suspend latency out of range");
   property p_susp_fall;
      $fell(dev_susp) |-> $past(lift);
   endproperty
   a_susp_fall: assert property (p_susp_fall)
      else $error("suspend lifted without cause");
   property p_holdoff;
      !cs_b && cmd_op == OP_SUSPEND |-> st_r.run + 16'h0001 >= st_r.min;
   endproperty
   a_holdoff: assert property (p_holdoff)
      else $error("suspend issued too early");
endmodule // frst_assertions

// ==== verification/tb.sv ====
// bench joining the host end and the device end through the link
// assumes shortened cycle-time parameters, same values on both ends
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import frst_pkg::*;
   localparam int unsigned SW = 40, NV = 60, SS = 90, PT = 120, PW = 150;
   localparam int unsigned RUN = 50;
   logic     core_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0;
   logic     hard_rst = 1'b0, op_clear = 1'b0, eng_done = 1'b0;
   frst_op_t req_op = OP_NONE;
   logic     req_ready, pend_susp, eng_run, eng_susp;
   frst_op_t pend_op, eng_op;
   int       bad_count = 0, checks_done = 0;
   int unsigned lo_cnt = 0;
   frst_op_t    cmd_q[$];
   int unsigned rec_q[$];
   logic [7:0]  rnd = 8'h49;
   frst_op_t    ops [11] = '{OP_READ, OP_VOL_WRITE, OP_STATUS_WRITE,
      OP_NVCFG_WRITE, OP_SUBSECT_ERASE, OP_PROT_PROGRAM, OP_PASS_PROGRAM,
      OP_PROGRAM, OP_OTP_PROGRAM, OP_LOCK_ERASE, OP_POWER_DOWN};
   int unsigned lens [11] = '{5, 5, SW, NV, SS, PT, PW, 3750, 3750, 3750,
                              3750};
   frst_link_if i_frst_link_if ();
   frst_host #(.STATUS_WRITE_CYC(SW), .NVCFG_WRITE_CYC(NV),
      .SSE_TIME_CYC(SS), .PROT_PROG_CYC(PT), .PASS_PROG_CYC(PW),
      .ERASE_RUN_CYC(RUN), .SSE_RUN_CYC(RUN)) i_frst_host (
      .core_clk(core_clk), .rst_b(rst_b), .lk(i_frst_link_if),
      .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready),
      .hard_rst(hard_rst), .op_clear(op_clear), .pend_op(pend_op),
      .pend_susp(pend_susp));
   frst_dev #(.STATUS_WRITE_CYC(SW), .NVCFG_WRITE_CYC(NV),
      .SSE_TIME_CYC(SS), .PROT_PROG_CYC(PT), .PASS_PROG_CYC(PW)) i_frst_dev (
      .core_clk(core_clk), .rst_b(rst_b), .lk(i_frst_link_if),
      .eng_done(eng_done), .eng_op(eng_op), .eng_run(eng_run),
      .eng_susp(eng_susp));
   frst_assertions #(.ERASE_RUN_CYC(RUN), .SSE_RUN_CYC(RUN))
      i_frst_assertions (.core_clk(core_clk), .rst_b(rst_b),
      .rst_pin_b(i_frst_link_if.rst_pin_b), .cs_b(i_frst_link_if.cs_b),
      .cmd_op(i_frst_link_if.cmd_op), .dev_ready(i_frst_link_if.dev_ready),
      .dev_susp(i_frst_link_if.dev_susp));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // host timers gate req_ready, so the wait also covers each recovery
   task automatic issue(input frst_op_t op);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      chk(n < 20000, 1'b1);
      cmd_q.push_back(op);
      req_valid = 1'b1;
      req_op    = op;
      tick(1);
      req_valid = 1'b0;
      req_op    = OP_NONE;
      tick(1);
   endtask
   task automatic strobe(input logic [2:0] v);
      {hard_rst, op_clear, eng_done} = v;
      tick(1);
      {hard_rst, op_clear, eng_done} = 3'b000;
      // one low cycle keeps back-to-back strobes apart
      tick(1);
   endtask
   task automatic wait_susp(input logic v);
      int n;
      n = 0;
      while (eng_susp !== v && n < 9000) begin
         tick(1);
         n++;
      end
      chk(i_frst_link_if.dev_susp, v);
   endtask
   // mid-cycle sampling keeps clear of the edge that moves the link
   always @(negedge core_clk) begin
      if (i_frst_link_if.cs_b === 1'b0) begin
         if (cmd_q.size() == 0) chk(1'b1, 1'b0);
         else chk(i_frst_link_if.cmd_op, cmd_q.pop_front());
      end
      if (i_frst_link_if.dev_ready === 1'b0) begin
         lo_cnt++;
      end else if (lo_cnt != 0) begin
         if (rec_q.size() == 0) chk(lo_cnt, 0);
         else if (rec_q[0] > 3000)
            chk(lo_cnt, rec_q.pop_front());
         else chk(lo_cnt, rec_q.pop_front());
         lo_cnt = 0;
      end
   end
   initial begin
      #750000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      frst_op_t    op, pend_e;
      int unsigned e;
      tick(10);
      rst_b = 1'b1;
      tick(2);
      chk({req_ready, i_frst_link_if.rst_pin_b, i_frst_link_if.cs_b,
           i_frst_link_if.dev_ready, i_frst_link_if.dev_susp, eng_run,
           eng_susp, pend_susp}, 8'hF0);
      chk({pend_op, eng_op}, {OP_NONE, OP_NONE});
      for (int i = 0; i < 22; i++) begin
         op = ops[i / 2];
         e  = lens[i / 2];
         issue(op);
         tick(3);
         // reads, volatile writes and power-down leave no op to track
         pend_e = (op inside {OP_READ, OP_VOL_WRITE, OP_POWER_DOWN}) ?
                  OP_NONE : op;
         chk(pend_op, pend_e);
         rnd = lfsr(rnd);
         // a finished op leaves only the short recovery on both ends
         if (rnd[0] && op != OP_POWER_DOWN) begin
            strobe(3'b011);
            e = 5;
         end
         tick(rnd[3:1]);
         if (i[0]) begin
            rec_q.push_back(e + 7);
            strobe(3'b100);
         end else begin
            rec_q.push_back(e);
            issue(OP_SOFT_RESET);
         end
      end
      issue(OP_SECTOR_ERASE);
      rec_q.push_back(3750);
      issue(OP_SUSPEND);
      wait_susp(1'b1);
      chk(pend_susp, 1'b1);
      issue(OP_PROGRAM);
      tick(2);
      chk({eng_run, eng_susp, eng_op}, {2'b11, OP_PROGRAM});
      strobe(3'b001);
      tick(1);
      chk({eng_run, eng_susp}, 2'b01);
      issue(OP_RESUME);
      wait_susp(1'b0);
      chk({eng_run, eng_op}, {1'b1, OP_SECTOR_ERASE});
      strobe(3'b011);
      strobe(3'b010);
      issue(OP_PROGRAM);
      rec_q.push_back(3125);
      issue(OP_SUSPEND);
      wait_susp(1'b1);
      issue(OP_SECTOR_ERASE);
      tick(2);
      chk({eng_run, i_frst_link_if.dev_ready}, 2'b01);
      rec_q.push_back(3750);
      issue(OP_SOFT_RESET);
      issue(OP_POWER_DOWN);
      chk(eng_susp, 1'b0);
      rec_q.push_back(3750);
      issue(OP_POWER_UP);
      issue(OP_READ);
      tick(5);
      chk(cmd_q.size() + rec_q.size(), 0);
      report_and_stop();
   end
endmodule // tb
